// file: hdl/ext_bus_if.sv
// external memory bus engine with apb register access
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module ext_bus_if (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // core request
    input  wire logic        REQ_VALID,
    input  wire logic [1:0]  REQ_KIND,
    input  wire logic        REQ_WIDE,
    input  wire logic [15:0] REQ_ADDR,
    input  wire logic [7:0]  REQ_WDATA,
    output logic             REQ_READY,
    // core answer
    output logic             RSP_VALID,
    output logic [7:0]       RSP_DATA,
    output logic             RSP_EXT,
    // port register access from the core
    input  wire logic        P0_SFR_WE,
    input  wire logic [7:0]  P0_SFR_WDATA,
    output logic [7:0]       P0_SFR,
    input  wire logic [7:0]  P2_SFR,
    // strap
    input  wire logic        EXTERNAL_ACCESS_SELECT_N,
    // strobes
    output logic             ALE,
    output logic             PROGRAM_FETCH_STROBE_N,
    output logic             RD_N,
    output logic             WR_N,
    // low port pins
    input  wire logic [7:0]  P0_IN,
    output logic [7:0]       P0_OUT,
    output logic [7:0]       P0_OE,
    // high port pins
    output logic [7:0]       P2_OUT,
    output logic [7:0]       P2_OE,
    output logic [7:0]       P2_STRONG
);
    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ext_bus_pkg::bus_state_t state;
    ext_bus_pkg::kind_t      kind;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        ext;
    logic        ale_allow;
    logic        latch_en;
    logic        accept;
    logic        tick;
    logic        last;
    logic [2:0]  phase;
    logic        is_data;
    logic        next_ext;
    logic        next_wide;
    logic        lo_drive;
    logic [7:0]  lo_value;
    logic        apb_setup;
    logic        apb_write;
    logic [7:0]  status_lo;

    // phase to state map for the running cycle
    function automatic ext_bus_pkg::bus_state_t phase_state(
        input logic       data,
        input logic [2:0] ph
    );
        if (!data) begin
            phase_state = (ph == 3'h0) ? ext_bus_pkg::ST_ADDR
                                       : ext_bus_pkg::ST_STROBE;
        end else if (ph < ext_bus_pkg::DATA_STROBE_FIRST) begin
            phase_state = ext_bus_pkg::ST_ADDR;
        end else if (ph <= ext_bus_pkg::DATA_STROBE_LAST) begin
            phase_state = ext_bus_pkg::ST_STROBE;
        end else begin
            phase_state = ext_bus_pkg::ST_TAIL;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // request acceptance and cycle classification
    assign accept  = REQ_VALID && REQ_READY;
    assign is_data = (kind != ext_bus_pkg::KIND_FETCH);

    // code goes outside when select is low or pc passes the internal limit
    always_comb begin
        if (REQ_KIND == ext_bus_pkg::KIND_FETCH) begin
            next_ext  = !EXTERNAL_ACCESS_SELECT_N
                     || (REQ_ADDR > ext_bus_pkg::INTERNAL_CODE_LIMIT);
            next_wide = 1'b1;
        end else begin
            next_ext  = 1'b1;
            next_wide = REQ_WIDE;
        end
    end

    // capture the request; the core must hold nothing after acceptance
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            kind  <= ext_bus_pkg::KIND_FETCH;
            wide  <= 1'b0;
            addr  <= 16'h0000;
            wdata <= 8'h00;
            ext   <= 1'b0;
        end else if (accept) begin
            kind  <= ext_bus_pkg::kind_t'(REQ_KIND);
            wide  <= next_wide;
            addr  <= REQ_ADDR;
            wdata <= REQ_WDATA;
            ext   <= next_ext;
        end
    end

    // latch strobe gating: internal code with enable clear stays quiet
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ale_allow <= 1'b1;
        end else if (accept) begin
            ale_allow <= !EXTERNAL_ACCESS_SELECT_N
                      || latch_en
                      || next_ext
                      || (REQ_KIND != ext_bus_pkg::KIND_FETCH);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle timing in oscillator periods
    osc_phase_gen #(
        .CLKS_PER_OSC (ext_bus_pkg::CLKS_PER_OSC),
        .PHASE_W      (3)
    ) u_phase (
        .clk    (CORE_CLK),
        .rst    (SYS_RST),
        .start  (accept),
        .length (REQ_KIND == ext_bus_pkg::KIND_FETCH ?
                 ext_bus_pkg::FETCH_OSC : ext_bus_pkg::DATA_OSC),
        .tick   (tick),
        .phase  (phase),
        .last   (last)
    );

    // bus state follows the phase counter
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state <= ext_bus_pkg::ST_IDLE;
        end else if (accept) begin
            state <= ext_bus_pkg::ST_ADDR;
        end else if (last) begin
            state <= ext_bus_pkg::ST_IDLE;
        end else if (tick) begin
            case (state)
                ext_bus_pkg::ST_IDLE: state <= ext_bus_pkg::ST_IDLE;
                default: state <= phase_state(is_data, phase + 3'h1);
            endcase
        end
    end

    // ready drops on acceptance so requests never overlap a cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            REQ_READY <= 1'b1;
        end else if (accept) begin
            REQ_READY <= 1'b0;
        end else if (last) begin
            REQ_READY <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobes, registered one clock behind the state
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ALE                    <= 1'b0;
            PROGRAM_FETCH_STROBE_N <= 1'b1;
            RD_N                   <= 1'b1;
            WR_N                   <= 1'b1;
        end else begin
            ALE <= (state == ext_bus_pkg::ST_ADDR) && (phase == 3'h0)
                && ale_allow;
            PROGRAM_FETCH_STROBE_N <= !((state == ext_bus_pkg::ST_STROBE)
                && !is_data && ext);
            RD_N <= !((state == ext_bus_pkg::ST_STROBE)
                && (kind == ext_bus_pkg::KIND_READ));
            WR_N <= !((state == ext_bus_pkg::ST_STROBE)
                && (kind == ext_bus_pkg::KIND_WRITE));
        end
    end

    // low port content: address first, then write data held to the end
    always_comb begin
        lo_drive = 1'b0;
        lo_value = addr[7:0];
        if (ext && (state == ext_bus_pkg::ST_ADDR) && (phase == 3'h0)) begin
            lo_drive = 1'b1;
        end else if (ext && (kind == ext_bus_pkg::KIND_WRITE)
                     && (state != ext_bus_pkg::ST_IDLE)) begin
            lo_drive = 1'b1;
            lo_value = wdata;
        end
    end

    // pins of both ports; the high byte is pc, pointer or port register
    port_drive u_ports (
        .clk       (CORE_CLK),
        .rst       (SYS_RST),
        .bus_on    (ext && (state != ext_bus_pkg::ST_IDLE)),
        .wide      (wide),
        .addr_hi   (addr[15:8]),
        .lo_drive  (lo_drive),
        .lo_value  (lo_value),
        .lo_latch  (P0_SFR),
        .hi_sfr    (P2_SFR),
        .lo_out    (P0_OUT),
        .lo_oe     (P0_OE),
        .hi_out    (P2_OUT),
        .hi_oe     (P2_OE),
        .hi_strong (P2_STRONG)
    );

    // low port latch: an external access wipes it to ones, core write loses
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            P0_SFR <= ext_bus_pkg::PORT_ALL_ONES;
        end else if (accept && next_ext) begin
            P0_SFR <= ext_bus_pkg::PORT_ALL_ONES;
        end else if (P0_SFR_WE) begin
            P0_SFR <= P0_SFR_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer to the core; data sampled while the read strobe is still low
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            RSP_VALID <= 1'b0;
            RSP_DATA  <= 8'h00;
            RSP_EXT   <= 1'b0;
        end else begin
            RSP_VALID <= last;
            if (tick && ext && (state == ext_bus_pkg::ST_STROBE)
                && (phase == (is_data ? ext_bus_pkg::DATA_STROBE_LAST
                                      : ext_bus_pkg::FETCH_STROBE_LAST))
                && (kind != ext_bus_pkg::KIND_WRITE)) begin
                RSP_DATA <= P0_IN;
            end
            if (last) begin
                RSP_EXT <= ext;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, ready comes in the access phase
    assign apb_setup = PSEL && !PENABLE;
    assign apb_write = PSEL && PENABLE && PREADY && PWRITE;
    assign status_lo = {4'h0, RSP_EXT, EXTERNAL_ACCESS_SELECT_N,
                        ext, (state != ext_bus_pkg::ST_IDLE)};

    // read data and error are prepared in the setup cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= apb_setup;
            PSLVERR <= apb_setup && (PADDR != ext_bus_pkg::SYSCTL_ADDR)
                    && (PADDR != ext_bus_pkg::STATUS_ADDR);
            if (apb_setup && (PADDR == ext_bus_pkg::SYSCTL_ADDR)) begin
                PRDATA <= 32'(latch_en) << ext_bus_pkg::LATCH_EN_BIT;
            end else if (apb_setup && (PADDR == ext_bus_pkg::STATUS_ADDR))
            begin
                PRDATA <= {16'h0000, RSP_DATA, status_lo};
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // system control: only the latch strobe enable is implemented
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            latch_en <= ext_bus_pkg::LATCH_EN_RESET;
        end else if (apb_write && (PADDR == ext_bus_pkg::SYSCTL_ADDR)) begin
            latch_en <= PWDATA[ext_bus_pkg::LATCH_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_strobe_split: assert property (
        !PROGRAM_FETCH_STROBE_N |-> RD_N && WR_N)
        else $error("fetch strobe overlaps a data strobe");

    a_latch_wiped: assert property (
        accept && next_ext |=> P0_SFR == 8'hFF)
        else $error("low port latch not set to ones");

    a_wide_high: assert property (
        ext && wide && state != ext_bus_pkg::ST_IDLE
        |=> P2_OUT == $past(addr[15:8]) && P2_OE == 8'hFF)
        else $error("high port lost address byte");

    a_narrow_high: assert property (
        !wide |=> P2_OUT == $past(P2_SFR))
        else $error("narrow move altered high port");

    a_strong_up: assert property (
        ext && wide && state == ext_bus_pkg::ST_STROBE
        |=> P2_STRONG == $past(addr[15:8]))
        else $error("strong pullup missing on address one");

    a_write_hold: assert property (
        $fell(WR_N) |-> $past(P0_OE) == 8'hFF ##3 $rose(WR_N)
        ##1 $past(P0_OE) == 8'hFF)
        else $error("write data not framing the strobe");

    a_no_int_program_fetch_strobe: assert property (
        accept && !next_ext |-> PROGRAM_FETCH_STROBE_N [*5])
        else $error("fetch strobe on internal fetch");

    a_data_len: assert property (
        accept && REQ_KIND != ext_bus_pkg::KIND_FETCH |-> ##6 last)
        else $error("data cycle not six periods");

    a_fetch_len: assert property (
        accept && REQ_KIND == ext_bus_pkg::KIND_FETCH |-> ##3 last)
        else $error("fetch cycle not three periods");

    a_ale_quiet: assert property (
        accept && !next_ext && EXTERNAL_ACCESS_SELECT_N && !latch_en
        && REQ_KIND == ext_bus_pkg::KIND_FETCH |-> !ALE [*4])
        else $error("latch strobe on gated internal fetch");

    a_ale_forced: assert property (
        accept && !EXTERNAL_ACCESS_SELECT_N |-> ##2 ALE)
        else $error("latch strobe missing with select low");

    a_reset_en: assert property (
        @(posedge CORE_CLK) $fell(SYS_RST) |-> latch_en)
        else $error("latch strobe enable clear after reset");

    c_ext_fetch: cover property (
        !PROGRAM_FETCH_STROBE_N ##1 RSP_VALID && RSP_EXT);
    c_read: cover property ($rose(RD_N) ##[0:2] RSP_VALID);
    c_write: cover property ($rose(WR_N));
    c_gated: cover property (accept && !latch_en && !next_ext);
endmodule // ext_bus_if

// file: hdl/ext_bus_pkg.sv
// constants and types shared by the external memory bus interface
package ext_bus_pkg;

    // time base: one core clock, oscillator periods counted in clocks
    localparam int CLK_PERIOD_NS = 100;
    localparam int OSC_PERIOD_NS = 100;
    localparam int CLKS_PER_OSC  =
        (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // bus cycle lengths in oscillator periods
    localparam logic [2:0] FETCH_OSC = 3'h3;
    localparam logic [2:0] DATA_OSC  = 3'h6;

    // phase marks inside data and fetch cycles
    localparam logic [2:0] DATA_STROBE_FIRST = 3'h2;
    localparam logic [2:0] DATA_STROBE_LAST  = 3'h4;
    localparam logic [2:0] FETCH_STROBE_LAST = 3'h2;

    // register indices (printed offsets) and their apb byte addresses
    localparam logic [11:0] SYSCTL_INDEX = 12'h0B1;
    localparam logic [11:0] STATUS_INDEX = 12'h0B2;
    localparam logic [11:0] SYSCTL_ADDR  = {SYSCTL_INDEX[9:0], 2'h0};
    localparam logic [11:0] STATUS_ADDR  = {STATUS_INDEX[9:0], 2'h0};

    // system_control layout and reset
    localparam int         LATCH_EN_BIT   = 5;
    localparam logic       LATCH_EN_RESET = 1'h1;

    // address space and port constants
    localparam logic [15:0] INTERNAL_CODE_LIMIT = 16'h1FFF;
    localparam logic [7:0]  PORT_ALL_ONES       = 8'hFF;

    typedef enum logic [1:0] {
        KIND_FETCH = 2'h0,
        KIND_READ  = 2'h1,
        KIND_WRITE = 2'h2
    } kind_t;

    // gray sequence idle -> addr -> strobe -> tail
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_ADDR   = 2'h1,
        ST_STROBE = 2'h3,
        ST_TAIL   = 2'h2
    } bus_state_t;

endpackage

// file: hdl/osc_phase_gen.sv
// oscillator period divider and phase counter for one bus cycle
`timescale 1ns/100ps
module osc_phase_gen #(
    parameter int CLKS_PER_OSC = 1,
    parameter int PHASE_W      = 3
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // cycle control
    input  wire logic               start,
    input  wire logic [PHASE_W-1:0] length,
    // progress
    output logic                    tick,
    output logic [PHASE_W-1:0]      phase,
    output logic                    last
);
    logic [7:0]         div;
    logic               run;
    logic [PHASE_W-1:0] len;

    // one-cycle enable per oscillator period while a cycle runs
    assign tick = run && (div == 8'(CLKS_PER_OSC - 1));
    assign last = tick && (phase == len - 1'b1);

    // divider restarts with each bus cycle so phases line up
    always_ff @(posedge clk) begin
        if (rst || start || tick) begin
            div <= 8'h00;
        end else if (run) begin
            div <= div + 8'h01;
        end
    end

    // phase counter and run flag
    always_ff @(posedge clk) begin
        if (rst) begin
            run   <= 1'b0;
            phase <= '0;
            len   <= '0;
        end else if (start) begin
            run   <= 1'b1;
            phase <= '0;
            len   <= length;
        end else if (last) begin
            run   <= 1'b0;
            phase <= '0;
        end else if (tick) begin
            phase <= phase + 1'b1;
        end
    end
endmodule // osc_phase_gen

// file: hdl/port_drive.sv
// registered pin drivers for the low (address/data) and high ports
`timescale 1ns/100ps
module port_drive (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // bus cycle view
    input  wire logic       bus_on,
    input  wire logic       wide,
    input  wire logic [7:0] addr_hi,
    input  wire logic       lo_drive,
    input  wire logic [7:0] lo_value,
    // port registers
    input  wire logic [7:0] lo_latch,
    input  wire logic [7:0] hi_sfr,
    // pins
    output logic [7:0]      lo_out,
    output logic [7:0]      lo_oe,
    output logic [7:0]      hi_out,
    output logic [7:0]      hi_oe,
    output logic [7:0]      hi_strong
);
    // low port: push-pull from the address/data path during bus use,
    // open drain from its own latch otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            lo_out <= 8'h00;
            lo_oe  <= 8'h00;
        end else if (bus_on) begin
            lo_out <= lo_value;
            lo_oe  <= lo_drive ? ext_bus_pkg::PORT_ALL_ONES : 8'h00;
        end else begin
            lo_out <= 8'h00;
            lo_oe  <= ~lo_latch;
        end
    end

    // high port: address byte with full-cycle strong pullup on wide
    // cycles; the sfr itself is never touched here
    always_ff @(posedge clk) begin
        if (rst) begin
            hi_out    <= ext_bus_pkg::PORT_ALL_ONES;
            hi_oe     <= 8'h00;
            hi_strong <= 8'h00;
        end else if (bus_on && wide) begin
            hi_out    <= addr_hi;
            hi_oe     <= ext_bus_pkg::PORT_ALL_ONES;
            hi_strong <= addr_hi;
        end else begin
            hi_out    <= hi_sfr;
            hi_oe     <= ~hi_sfr;
            hi_strong <= 8'h00;
        end
    end
endmodule // port_drive

// file: sim/ext_mem_model.sv
// behavioural external memories with their address latch
`timescale 1ns/100ps
module ext_mem_model (
    // clock
    input  wire logic       clk,
    // strobes from the device
    input  wire logic       ale,
    input  wire logic       fetch_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    // bus pins
    input  wire logic [7:0] p0_out,
    input  wire logic [7:0] p2_out,
    output logic [7:0]      p0_in,
    output logic [7:0]      wr_byte
);
    logic [7:0] lat;
    logic [7:0] mem_byte;
    logic       wr_q = 1'h1;
    // memory answers while a read strobe is low; a released bus shows
    // the inverse so that a sample taken too late cannot pass
    assign mem_byte = lat ^ p2_out ^ 8'h3C;
    assign p0_in = (fetch_n && rd_n) ? ~mem_byte : mem_byte;
    // address latch follows the low port while the strobe is high
    always @(posedge clk) begin
        if (ale) lat <= p0_out;
        wr_q <= wr_n;
        if (!wr_q && wr_n) wr_byte <= p0_out;
    end
endmodule // ext_mem_model

// file: sim/tb.sv
// self-checking bench for the external memory bus interface
`timescale 1ns/100ps
module tb;
    logic CORE_CLK = 1'h0, SYS_RST = 1'h1;
    logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, PREADY, PSLVERR;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic REQ_VALID = 1'h0, REQ_WIDE = 1'h0, P0_SFR_WE = 1'h0;
    logic REQ_READY, RSP_VALID, RSP_EXT, ALE, RD_N, WR_N;
    logic PROGRAM_FETCH_STROBE_N, EXTERNAL_ACCESS_SELECT_N = 1'h0;
    logic [1:0] REQ_KIND = 2'h0;
    logic [15:0] REQ_ADDR = 16'h0, a_seen;
    logic [7:0] REQ_WDATA = 8'h00, P0_SFR_WDATA = 8'h00, P2_SFR = 8'h5C;
    logic [7:0] RSP_DATA, P0_SFR, P0_IN, P0_OUT, P0_OE, P2_OUT, P2_OE;
    logic [7:0] P2_STRONG, wr_byte, p2_seen, st_seen;
    int fails = 0, samples_checked = 0, ticks = 0;
    int n_ale = 0, n_ps = 0, n_rd = 0, n_wr = 0;
    typedef struct packed {
        logic [1:0] kind;
        logic wide, sel_n, en, ext, ale;
        logic [15:0] addr;
        logic [7:0] wdata;
    } row_t;
    // kind wide sel_n en | ext ale | addr wdata
    row_t rows [9] = '{
        '{2'h0,1'h1,1'h0,1'h1,1'h1,1'h1,16'h1234,8'h00},
        '{2'h0,1'h1,1'h1,1'h1,1'h0,1'h1,16'h1FFF,8'h00},
        '{2'h0,1'h1,1'h1,1'h0,1'h0,1'h0,16'h1FFF,8'h00},
        '{2'h0,1'h1,1'h1,1'h0,1'h1,1'h1,16'h2000,8'h00},
        '{2'h0,1'h1,1'h0,1'h0,1'h1,1'h1,16'h0010,8'h00},
        '{2'h1,1'h1,1'h1,1'h0,1'h1,1'h1,16'hABCD,8'h00},
        '{2'h1,1'h0,1'h1,1'h1,1'h1,1'h1,16'h0042,8'h00},
        '{2'h2,1'h1,1'h1,1'h0,1'h1,1'h1,16'h8001,8'h96},
        '{2'h2,1'h0,1'h0,1'h1,1'h1,1'h1,16'h00C3,8'h69}};
    ////////////////////////////////////////////////////////////////////
    always #50 CORE_CLK = ~CORE_CLK;
    ext_bus_if ext_bus_if_inst (.CORE_CLK, .SYS_RST, .PSEL, .PENABLE,
        .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .REQ_VALID,
        .REQ_KIND, .REQ_WIDE, .REQ_ADDR, .REQ_WDATA, .REQ_READY,
        .RSP_VALID, .RSP_DATA, .RSP_EXT, .P0_SFR_WE, .P0_SFR_WDATA,
        .P0_SFR, .P2_SFR, .EXTERNAL_ACCESS_SELECT_N, .ALE,
        .PROGRAM_FETCH_STROBE_N, .RD_N, .WR_N, .P0_IN, .P0_OUT, .P0_OE,
        .P2_OUT, .P2_OE, .P2_STRONG);
    ext_mem_model ext_mem_model_inst (.clk(CORE_CLK), .ale(ALE),
        .fetch_n(PROGRAM_FETCH_STROBE_N), .rd_n(RD_N), .wr_n(WR_N),
        .p0_out(P0_OUT), .p2_out(P2_OUT), .p0_in(P0_IN), .wr_byte);
    // pin monitor: running strobe counts, what the pins showed; timeout
    always @(posedge CORE_CLK) begin
        ticks <= ticks + 1;
        n_ale <= n_ale + ALE;
        n_ps <= n_ps + !PROGRAM_FETCH_STROBE_N;
        n_rd <= n_rd + !RD_N;
        n_wr <= n_wr + !WR_N;
        if (ALE) a_seen <= {P0_OE, P0_OUT};
        if (!(RD_N && WR_N && PROGRAM_FETCH_STROBE_N)) begin
            p2_seen <= P2_OUT;
            st_seen <= P2_STRONG;
        end
        if (ticks == 3000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [32:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [32:0] r);
        PSEL <= 1'h1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'h1;
        @(posedge CORE_CLK);
        while (PREADY !== 1'h1) @(posedge CORE_CLK);
        r = {PSLVERR, PRDATA};
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CORE_CLK);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        row_t w;
        logic [32:0] r;
        logic [7:0] hi;
        int lat, a0, p0, r0, w0;
        repeat (10) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        @(posedge CORE_CLK);
        foreach (rows[i]) begin
            w = rows[i];
            hi = (w.wide || w.kind == 2'h0) ? w.addr[15:8] : P2_SFR;
            EXTERNAL_ACCESS_SELECT_N <= w.sel_n;
            apb(1'h1, ext_bus_pkg::SYSCTL_ADDR, {26'h0, w.en, 5'h0}, r);
            P0_SFR_WE <= 1'h1;
            @(posedge CORE_CLK);
            P0_SFR_WE <= 1'h0;
            REQ_VALID <= 1'h1;
            REQ_KIND <= w.kind;
            REQ_WIDE <= w.wide;
            REQ_ADDR <= w.addr;
            REQ_WDATA <= w.wdata;
            @(posedge CORE_CLK);
            while (REQ_READY !== 1'h1) @(posedge CORE_CLK);
            {a0, p0, r0, w0} = {n_ale, n_ps, n_rd, n_wr};
            REQ_VALID <= 1'h0;
            lat = 0;
            do begin
                @(posedge CORE_CLK);
                lat++;
            end while (RSP_VALID !== 1'h1 && lat < 20);
            repeat (2) @(posedge CORE_CLK);
            chk("latency", lat, w.kind == 2'h0 ? 4 : 7);
            chk("external", RSP_EXT, w.ext);
            chk("latch strobes", n_ale - a0, w.ale);
            chk("fetch strobes", n_ps - p0, w.ext && !w.kind ? 2 : 0);
            chk("read strobes", n_rd - r0, w.kind == 2'h1 ? 3 : 0);
            chk("write strobes", n_wr - w0, w.kind == 2'h2 ? 3 : 0);
            chk("low latch", P0_SFR, w.ext ? 8'hFF : 8'h00);
            if (w.ext) begin
                chk("address low", a_seen, {8'hFF, w.addr[7:0]});
                chk("high port", p2_seen, hi);
                if (w.wide) chk("strong", st_seen, hi);
            end
            if (w.ext && w.kind != 2'h2)
                chk("data", RSP_DATA, w.addr[7:0] ^ hi ^ 8'h3C);
            if (w.kind == 2'h2) chk("write", wr_byte, w.wdata);
            $display("row %0d done", i);
        end
        // after the last row: narrow read byte 42^5C^3C, external write
        apb(1'h0, ext_bus_pkg::STATUS_ADDR, 32'h0, r);
        chk("status", r, {1'h0, 16'h0000, 8'h22, 8'h0A});
        apb(1'h1, ext_bus_pkg::SYSCTL_ADDR, 32'hFFFFFFFF, r);
        apb(1'h0, ext_bus_pkg::SYSCTL_ADDR, 32'h0, r);
        chk("reserved bits", r, 33'h20);
        apb(1'h1, ext_bus_pkg::SYSCTL_ADDR, 32'h0, r);
        SYS_RST <= 1'h1;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        @(posedge CORE_CLK);
        apb(1'h0, ext_bus_pkg::SYSCTL_ADDR, 32'h0, r);
        chk("control reset", r, 33'h20);
        apb(1'h0, 12'h000, 32'h0, r);
        chk("unmapped", r, {1'h1, 32'h0});
        $display("register tests done");
        give_verdict();
    end
endmodule // tb
